/* src/ptt_timer.sv */
// periodic tick timer: 24-bit down counter with register port and interrupt
//
// Functional notes
// - registers decoded at base plus offset 0xe010
// - control bit 0 enables counting
// - control bit 1 gates exception request
// - control bit 2 selects count source
// - no reference forces source select high
// - wrap flag sticky, cleared by read
// - reload field loaded on reaching zero
// - flag and request only on 1-to-0
// - count write clears count and flag
// - calibration bit 30 reports inexact value
// - calibration low field holds 100Hz reload
// - external source advances on microsecond pulse
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module ptt_timer #(
    parameter logic NO_REFERENCE = 1'b0, // tie high when no reference tick exists
    parameter logic CAL_SKEW = 1'b0, // calibration inexact flag
    parameter logic [23:0] CAL_TEN_MS = 24'h00_0000 // 10 ms reload, zero if unknown
) (
    input wire logic SYS_CLK_I,
    input wire logic ARST_N_I,
    input wire logic [31:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic REF_TICK_I,
    output logic [31:0] RDATA_O,
    output logic TICK_REQ_O,
    output logic IRQ_O
);
    logic rst_sync1_q; // reset release stage one
    logic rst_n; // synchronised reset
    ptt_pkg::ptt_bus_req_t req; // bundled bus request
    logic ref_tick_sync; // reference pulse after synchroniser
    logic ref_tick_prev_q; // last sampled reference level
    logic ref_tick_pulse; // one cycle per reference rising edge
    logic enable_q; // counting enabled
    logic req_en_q; // exception request gate
    logic source_q; // stored source select
    logic source_eff; // source select after forcing
    logic wrap_q; // sticky wrap-seen flag
    logic [23:0] reload_q; // reload field
    logic [23:0] count_q; // live count
    logic tick_req_q; // registered exception request
    logic [ptt_pkg::IRQ_W-1:0] irq_stat_q; // sticky interrupt status
    logic [ptt_pkg::IRQ_W-1:0] irq_en_q; // interrupt enable mask
    logic [31:0] rdata_q; // read data register
    logic hit_csr; // control word selected
    logic hit_rvr; // reload register selected
    logic hit_cvr; // current count selected
    logic hit_cal; // calibration word selected
    logic hit_ist; // interrupt status selected
    logic hit_ien; // interrupt enable selected
    logic hit_icl; // interrupt clear selected
    logic qual_tick; // this cycle is a counted tick
    logic wrap_evt; // count moved from one to zero
    logic csr_read; // software read of control word
    logic cvr_write; // software write of current count

    // release reset through two flip-flops, asserted asynchronously
    // a clean release edge keeps some flops from leaving reset a cycle early
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            // both stages clear at once
            rst_sync1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_n <= rst_sync1_q;
        end
    end

    // bundle the bus pins; all fields are taken on the same edge
    assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

    // full 32-bit address compare against base plus offset
    // no partial decode, so aliases elsewhere in the private space stay silent
    assign hit_csr = (req.addr == (ptt_pkg::PRIVATE_PERIPHERAL_BASE
        | ptt_pkg::OFF_CONTROL_STATUS));
    assign hit_rvr = (req.addr == (ptt_pkg::PRIVATE_PERIPHERAL_BASE
        | ptt_pkg::OFF_RELOAD_VALUE));
    assign hit_cvr = (req.addr == (ptt_pkg::PRIVATE_PERIPHERAL_BASE
        | ptt_pkg::OFF_CURRENT_COUNT));
    assign hit_cal = (req.addr == (ptt_pkg::PRIVATE_PERIPHERAL_BASE
        | ptt_pkg::OFF_CALIBRATION));
    assign hit_ist = (req.addr == (ptt_pkg::PRIVATE_PERIPHERAL_BASE
        | ptt_pkg::OFF_IRQ_STATUS));
    assign hit_ien = (req.addr == (ptt_pkg::PRIVATE_PERIPHERAL_BASE
        | ptt_pkg::OFF_IRQ_ENABLE));
    assign hit_icl = (req.addr == (ptt_pkg::PRIVATE_PERIPHERAL_BASE
        | ptt_pkg::OFF_IRQ_CLEAR));

    // the two accesses with side effects on the wrap flag
    assign csr_read = req.rd && hit_csr;
    assign cvr_write = req.wr && hit_cvr;

    // reference tick comes from another block's timing, so synchronise it
    ptt_sync #(
        .WIDTH(1)
    ) u_ref_sync (
        .clk_i(SYS_CLK_I),
        .rst_n_i(rst_n),
        .d_i(REF_TICK_I),
        .q_o(ref_tick_sync)
    );

    // edge detect so a stretched pulse counts once
    // previous level resets low, the idle level of the pin, so reset makes no edge
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            ref_tick_prev_q <= 1'b0;
        end else begin
            ref_tick_prev_q <= ref_tick_sync;
        end
    end
    assign ref_tick_pulse = ref_tick_sync && !ref_tick_prev_q;

    // stored select is overridden when no reference exists
    // the stored bit still follows writes, only its use and its reading are forced
    assign source_eff = source_q | NO_REFERENCE;
    // processor clock counts every edge, reference only on its pulse
    assign qual_tick = enable_q && (source_eff || ref_tick_pulse);
    // only a decrement from one raises the event; reload of zero never does
    // a count write in the same cycle cancels the event, the clear wins there
    assign wrap_evt = qual_tick && (count_q == 24'h00_0001) && !cvr_write;

    // control word fields
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
            req_en_q <= 1'b0;
            source_q <= 1'b0;
        end else if (req.wr && hit_csr) begin
            // only bits 2:0 are stored; flag and reserved bits of the write drop
            enable_q <= req.wdata[ptt_pkg::CSR_ENABLE_BIT];
            req_en_q <= req.wdata[ptt_pkg::CSR_REQ_EN_BIT];
            source_q <= req.wdata[ptt_pkg::CSR_SOURCE_BIT];
        end
    end

    // sticky wrap flag: a wrap in the clearing cycle wins over the clear
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            wrap_q <= 1'b0;
        end else if (wrap_evt) begin
            wrap_q <= 1'b1;
        end else if (csr_read || cvr_write) begin
            // a control word read or a count write clears it
            wrap_q <= 1'b0;
        end
    end

    // reload field, upper byte ignored
    // the value is kept while the counter is stopped
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            reload_q <= ptt_pkg::RELOAD_RESET;
        end else if (req.wr && hit_rvr) begin
            reload_q <= req.wdata[ptt_pkg::COUNT_W-1:0];
        end
    end

    // down counter; a write clears it and takes priority over counting
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= ptt_pkg::COUNT_RESET;
        end else if (cvr_write) begin
            // software write wins over a tick in the same cycle
            count_q <= ptt_pkg::COUNT_RESET;
        end else if (qual_tick) begin
            if (count_q == ptt_pkg::COUNT_RESET) begin
                // zero is the reload point, whatever the reload holds
                count_q <= reload_q;
            end else begin
                // ordinary step toward zero
                count_q <= count_q - 24'h00_0001;
            end
        end
    end

    // one-cycle exception request toward the interrupt controller
    // registered so the request never glitches on the decode of the count
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            tick_req_q <= 1'b0;
        end else begin
            tick_req_q <= wrap_evt && req_en_q;
        end
    end
    assign TICK_REQ_O = tick_req_q;

    // interrupt status: set on wrap, set beats write-one clear
    // the status is sticky; only a one written to the clear word drops it
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= '0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((req.wr && hit_icl) ?
                req.wdata[ptt_pkg::IRQ_W-1:0] : {ptt_pkg::IRQ_W{1'b0}}))
                | {ptt_pkg::IRQ_W{wrap_evt}};
        end
    end

    // interrupt enable mask
    // masking acts on the level output only, the status still records wraps
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q <= '0;
        end else if (req.wr && hit_ien) begin
            irq_en_q <= req.wdata[ptt_pkg::IRQ_W-1:0];
        end
    end
    assign IRQ_O = |(irq_stat_q & irq_en_q);

    // read mux; unmapped and write-only addresses read zero
    always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= ptt_pkg::READ_ZERO;
        end else if (req.rd) begin
            // clear first, then fill only the implemented fields
            rdata_q <= ptt_pkg::READ_ZERO;
            // control word: the source bit shows the forced value
            if (hit_csr) begin
                rdata_q[ptt_pkg::CSR_ENABLE_BIT] <= enable_q;
                rdata_q[ptt_pkg::CSR_REQ_EN_BIT] <= req_en_q;
                rdata_q[ptt_pkg::CSR_SOURCE_BIT] <= source_eff;
                rdata_q[ptt_pkg::CSR_WRAP_BIT] <= wrap_q;
            end else if (hit_rvr) begin
                rdata_q[ptt_pkg::COUNT_W-1:0] <= reload_q;
            end else if (hit_cvr) begin
                rdata_q[ptt_pkg::COUNT_W-1:0] <= count_q;
            end else if (hit_cal) begin
                // calibration contents are fixed when the block is built
                rdata_q[ptt_pkg::CAL_NO_REFERENCE_INDICATOR_BIT] <= NO_REFERENCE;
                rdata_q[ptt_pkg::CAL_SKEW_BIT] <= CAL_SKEW;
                rdata_q[ptt_pkg::COUNT_W-1:0] <= CAL_TEN_MS;
            end else if (hit_ist) begin
                rdata_q[ptt_pkg::IRQ_W-1:0] <= irq_stat_q;
            end else if (hit_ien) begin
                rdata_q[ptt_pkg::IRQ_W-1:0] <= irq_en_q;
            end
        end
    end
    assign RDATA_O = rdata_q;

    // checks beside the logic, off while the synchronised reset is low
    // a decrement from one that no count write cancels
    sequence wrap_step_s;
        qual_tick && count_q == 24'h00_0001 && !cvr_write;
    endsequence

    // a control word read; its answer stands one cycle later
    sequence ctrl_read_s;
        req.rd && hit_csr;
    endsequence

    // a reload read; its answer stands one cycle later
    sequence reload_read_s;
        req.rd && hit_rvr;
    endsequence

    // a calibration read; its answer stands one cycle later
    sequence calib_read_s;
        req.rd && hit_cal;
    endsequence

    // a count read; its answer stands one cycle later
    sequence count_read_s;
        req.rd && hit_cvr;
    endsequence

    // an ordinary counted step from a count above one
    sequence plain_step_s;
        qual_tick && count_q > 24'h00_0001 && !cvr_write;
    endsequence

    wrap_sets_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        wrap_step_s |=> wrap_q)
        else $error("wrap did not set flag");
    read_clears_flag_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        csr_read && !wrap_evt |=> !wrap_q)
        else $error("flag survived read");
    zero_reloads_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        qual_tick && count_q == 24'h00_0000 && !cvr_write |=> count_q == $past(reload_q))
        else $error("no reload at zero");
    request_gated_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        wrap_step_s ##0 req_en_q == 1'b0 |=> !TICK_REQ_O)
        else $error("request without enable");
    request_raised_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        TICK_REQ_O |-> $past(count_q) == 24'h00_0001 && count_q == 24'h00_0000)
        else $error("request not from one to zero");
    disabled_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        !enable_q && !cvr_write |=> $stable(count_q))
        else $error("count moved while disabled");
    write_clears_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        cvr_write |=> count_q == 24'h00_0000 && !wrap_q)
        else $error("count write did not clear");
    ref_pace_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        enable_q && !source_eff && !ref_tick_pulse && !cvr_write |=> $stable(count_q))
        else $error("count moved without reference pulse");
    force_source_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        ctrl_read_s ##0 NO_REFERENCE |=> RDATA_O[ptt_pkg::CSR_SOURCE_BIT])
        else $error("source not forced");
    reserved_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        req.rd && hit_csr |=> RDATA_O[31:17] == 15'h0000 && RDATA_O[15:3] == 13'h0000)
        else $error("reserved bits not zero");

    // a plain step lowers the count by exactly one
    count_step_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        plain_step_s |=> count_q == $past(count_q) - 24'h00_0001)
        else $error("count did not step by one");
    // the flag bit of a control read shows the flag before the read cleared it
    flag_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        ctrl_read_s |=> RDATA_O[ptt_pkg::CSR_WRAP_BIT] == $past(wrap_q))
        else $error("flag read wrong");
    // the reload reads back in its low field with a zero top byte
    reload_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        reload_read_s |=> RDATA_O == {8'h00, $past(reload_q)})
        else $error("reload read wrong");
    // the live count reads back with a zero top byte
    count_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        count_read_s |=> RDATA_O == {8'h00, $past(count_q)})
        else $error("count read wrong");
    // the calibration word carries only its three fixed fields
    calib_read_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        calib_read_s |=> RDATA_O == {NO_REFERENCE, CAL_SKEW, 6'h00, CAL_TEN_MS})
        else $error("calibration read wrong");
    // one wrap gives one request cycle, never two in a row
    request_single_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        TICK_REQ_O |=> !TICK_REQ_O)
        else $error("request longer than one cycle");
    // a zero reload keeps the count at zero and raises nothing
    zero_reload_quiet_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        qual_tick && count_q == 24'h00_0000 && reload_q == 24'h00_0000 && !cvr_write
        |=> !TICK_REQ_O && count_q == 24'h00_0000)
        else $error("zero reload not quiet");
    // a reference level held high still counts only once
    ref_single_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        ref_tick_pulse |=> !ref_tick_pulse)
        else $error("reference pulse repeated");
    // a stopped counter raises no request
    disabled_no_wrap_a: assert property (@(posedge SYS_CLK_I) disable iff (!rst_n)
        !enable_q |=> !TICK_REQ_O)
        else $error("request while disabled");
endmodule

/* include/ptt_pkg.sv */
// package with register map, field positions and carrier types of the tick timer
package ptt_pkg;
    // address map: private peripheral base plus block offsets
    localparam logic [31:0] PRIVATE_PERIPHERAL_BASE = 32'he000_0000;
    localparam logic [31:0] OFF_CONTROL_STATUS = 32'h0000_e010;
    localparam logic [31:0] OFF_RELOAD_VALUE = 32'h0000_e014;
    localparam logic [31:0] OFF_CURRENT_COUNT = 32'h0000_e018;
    localparam logic [31:0] OFF_CALIBRATION = 32'h0000_e01c;
    localparam logic [31:0] OFF_IRQ_STATUS = 32'h0000_e020;
    localparam logic [31:0] OFF_IRQ_ENABLE = 32'h0000_e024;
    localparam logic [31:0] OFF_IRQ_CLEAR = 32'h0000_e028;
    // control word field positions
    localparam int CSR_ENABLE_BIT = 0;
    localparam int CSR_REQ_EN_BIT = 1;
    localparam int CSR_SOURCE_BIT = 2;
    localparam int CSR_WRAP_BIT = 16;
    // calibration field positions
    localparam int CAL_NO_REFERENCE_INDICATOR_BIT = 31;
    localparam int CAL_SKEW_BIT = 30;
    localparam int COUNT_W = 24;
    // reset values
    localparam logic [23:0] RELOAD_RESET = 24'h00_0000;
    localparam logic [23:0] COUNT_RESET = 24'h00_0000;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    // interrupt status bit positions
    localparam int IRQ_WRAP_BIT = 0;
    localparam int IRQ_W = 1;

    // register bus request bundle
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ptt_bus_req_t;
endpackage

/* src/ptt_sync.sv */
// two flip-flop synchroniser for single-bit levels
`timescale 1ns/100ps
module ptt_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by second stage

    // chained stages guard against metastability
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

/* dv/tb_ptt_timer.sv */
// self-checking bench for the tick timer with a small integer register model
`timescale 1ns/100ps
module tb_ptt_timer;
    localparam logic [31:0] BA = ptt_pkg::PRIVATE_PERIPHERAL_BASE;
    localparam logic [31:0] A_CTRL = BA | ptt_pkg::OFF_CONTROL_STATUS;
    localparam logic [31:0] A_RLD = BA | ptt_pkg::OFF_RELOAD_VALUE;
    localparam logic [31:0] A_CNT = BA | ptt_pkg::OFF_CURRENT_COUNT;
    localparam logic [31:0] A_CAL = BA | ptt_pkg::OFF_CALIBRATION;
    localparam logic [31:0] A_STAT = BA | ptt_pkg::OFF_IRQ_STATUS;
    localparam logic [31:0] A_IEN = BA | ptt_pkg::OFF_IRQ_ENABLE;
    localparam logic [31:0] A_ICLR = BA | ptt_pkg::OFF_IRQ_CLEAR;
    // bus and pin stimulus
    logic SYS_CLK_I, ARST_N_I, WR_I, RD_I, REF_TICK_I, TICK_REQ_O, IRQ_O;
    logic [31:0] ADDR_I, WDATA_I, RDATA_O, rdata_b, rv;
    int err_count, cmp_count, cyc, last_pulse, gap, pulses, refc, r, p;
    bit ref_run;
    // model state: control bits and sticky wrap flag
    int m_ctrl, m_flag;

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_count++; \
    $display("MISMATCH %s exp=%h got=%h", nm, ex, got); end end

    ptt_timer #(.NO_REFERENCE(1'b0), .CAL_SKEW(1'b1), .CAL_TEN_MS(24'h09_c3ff)) ptt_timer_inst (
        .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .REF_TICK_I(REF_TICK_I), .RDATA_O(RDATA_O),
        .TICK_REQ_O(TICK_REQ_O), .IRQ_O(IRQ_O));
    // second copy built without a reference tick, sharing the bus
    ptt_timer #(.NO_REFERENCE(1'b1)) ptt_timer_no_reference_indicator_inst (
        .SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
        .WR_I(WR_I), .RD_I(RD_I), .REF_TICK_I(REF_TICK_I), .RDATA_O(rdata_b),
        .TICK_REQ_O(), .IRQ_O());

    // 250 MHz clock
    initial begin
        SYS_CLK_I = 1'b0;
        forever #2 SYS_CLK_I = ~SYS_CLK_I;
    end

    // request monitor: counts pulses and the spacing of the last two
    always @(posedge SYS_CLK_I) begin
        cyc <= cyc + 1;
        if (TICK_REQ_O === 1'b1) begin
            gap <= cyc - last_pulse;
            last_pulse <= cyc;
            pulses <= pulses + 1;
        end
    end

    // reference tick: one-cycle pulse every 8 clocks while running
    always @(posedge SYS_CLK_I) begin
        refc <= (refc == 7) ? 0 : refc + 1;
        REF_TICK_I <= ref_run && (refc == 0);
    end

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge SYS_CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge SYS_CLK_I);
        WR_I <= 1'b0;
        // step past the edge so outputs already show the write
        #1;
    endtask

    // read data stands from the cycle after the strobe until the next read
    task automatic rd(input logic [31:0] a);
        @(posedge SYS_CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge SYS_CLK_I);
        RD_I <= 1'b0;
        #1 rv = RDATA_O;
    endtask

    // a control read clears the sticky flag, so the model does too
    task automatic rd_ctrl();
        rd(A_CTRL);
        `CHK("ctrl", {15'h0000, m_flag[0], 13'h0000, m_ctrl[2:0]}, rv)
        m_flag = 0;
    endtask

    // run with request enabled and measure the steady spacing of requests
    task automatic run_gap(input int src, input int exp_gap);
        int n;
        wr(A_CNT, 32'h0000_0000);
        wr(A_CTRL, 32'(3 | (src << 2)));
        p = pulses;
        n = 0;
        while (pulses < p + 3 && n < 3000) begin
            @(posedge SYS_CLK_I);
            n++;
        end
        `CHK("req_seen", 1'b1, n < 3000)
        `CHK("req_gap", exp_gap, gap)
        wr(A_CTRL, 32'h0000_0000);
        m_ctrl = 0;
        m_flag = 1;
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial begin
        #100_000;
        err_count++;
        finish_test();
    end

    initial begin
        ARST_N_I = 1'b0; WR_I = 1'b0; RD_I = 1'b0;
        ADDR_I = 32'h0000_0000; WDATA_I = 32'h0000_0000; ref_run = 1'b0;
        m_ctrl = 0; m_flag = 0;
        r = $urandom(67785);
        repeat (5) @(posedge SYS_CLK_I);
        ARST_N_I <= 1'b1;
        repeat (4) @(posedge SYS_CLK_I);
        // reset contents, calibration and an unmapped hole
        rd_ctrl();
        rd(A_RLD); `CHK("reload_rst", 32'h0000_0000, rv)
        rd(A_CNT); `CHK("count_rst", 32'h0000_0000, rv)
        rd(A_CAL); `CHK("calib", 32'h4009_c3ff, rv)
        `CHK("calib_no_reference_indicator", 32'h8000_0000, rdata_b)
        rd(BA | 32'h0000_e030); `CHK("unmapped", 32'h0000_0000, rv)
        // reserved bits ignore writes and read zero
        wr(A_CTRL, 32'hffff_fffc); m_ctrl = 4;
        rd_ctrl();
        wr(A_RLD, 32'hff12_3456);
        rd(A_RLD); `CHK("reload_rsv", 32'h0012_3456, rv)
        // without a reference the source bit reads one after writing zero
        wr(A_CTRL, 32'h0000_0000); m_ctrl = 0;
        rd(A_CTRL); `CHK("no_reference_indicator_src", 1'b1, rdata_b[2])
        // processor clock: period is reload plus one
        r = 2 + ($urandom % 6);
        wr(A_RLD, 32'(r));
        wr(A_IEN, 32'h0000_0001);
        run_gap(1, r + 1);
        `CHK("irq_set", 1'b1, IRQ_O)
        rd(A_STAT); `CHK("stat_set", 32'h0000_0001, rv)
        rd_ctrl();
        rd_ctrl();
        // disabled counter holds its value
        rd(A_CNT); p = int'(rv);
        `CHK("count_range", 1'b1, p <= r)
        repeat (20) @(posedge SYS_CLK_I);
        rd(A_CNT); `CHK("count_hold", 32'(p), rv)
        // mask then clear the interrupt
        wr(A_IEN, 32'h0000_0000);
        `CHK("irq_mask", 1'b0, IRQ_O)
        wr(A_ICLR, 32'h0000_0001);
        rd(A_STAT); `CHK("stat_clr", 32'h0000_0000, rv)
        wr(A_IEN, 32'h0000_0001);
        // external reference: one step per reference pulse
        ref_run <= 1'b1;
        run_gap(0, (r + 1) * 8);
        ref_run <= 1'b0;
        // writing the count clears count and flag
        wr(A_CNT, 32'h0000_0001); m_flag = 0;
        rd_ctrl();
        rd(A_CNT); `CHK("count_clr", 32'h0000_0000, rv)
        wr(A_ICLR, 32'h0000_0001);
        // request gate off: flag still sets but no request
        p = pulses;
        wr(A_CTRL, 32'h0000_0005);
        repeat (40) @(posedge SYS_CLK_I);
        wr(A_CTRL, 32'h0000_0000);
        `CHK("gated_req", 0, pulses - p)
        m_flag = 1;
        rd_ctrl();
        // reload zero never wraps
        wr(A_ICLR, 32'h0000_0001);
        wr(A_RLD, 32'h0000_0000);
        wr(A_CNT, 32'h0000_0000);
        p = pulses;
        wr(A_CTRL, 32'h0000_0007);
        repeat (40) @(posedge SYS_CLK_I);
        wr(A_CTRL, 32'h0000_0000);
        `CHK("zero_req", 0, pulses - p)
        `CHK("zero_irq", 1'b0, IRQ_O)
        rd_ctrl();
        finish_test();
    end
endmodule
